// File: rtl/sfn_pkg.sv
/*
  Package for the packed floating-point exception and NaN-result unit:
  control/status register map, flag positions, operation codes and the
  fixed result patterns.
  Assumes a 32-bit register port and a 128-bit operand datapath.
*/
package sfn_pkg;
  // Register map (byte addresses)
  localparam logic [3:0]  SFN_ADDR_CSR   = 4'h0;
  localparam int          SFN_AW         = 4;
  // Flag and mask positions inside the control/status register
  localparam int          SFN_FLAG_LSB   = 0;
  localparam int          SFN_MASK_LSB   = 8;
  localparam int          SFN_NEXC       = 6;
  localparam int          SFN_F_INV      = 0;
  localparam int          SFN_F_DEN      = 1;
  localparam int          SFN_F_DZ       = 2;
  localparam int          SFN_F_OVF      = 3;
  localparam int          SFN_F_UNF      = 4;
  localparam int          SFN_F_INX      = 5;
  // Reset values: all flags clear, all exceptions masked
  localparam logic [5:0]  SFN_FLAG_RST   = 6'h00;
  localparam logic [5:0]  SFN_MASK_RST   = 6'h3f;
  // Lanes and timing
  localparam int          SFN_LANES      = 4;
  localparam int          SFN_LATENCY    = 1;
  // Exception vector raised for unmasked conditions
  localparam logic [7:0]  SFN_EXC_VECTOR = 8'h13;
  // Result patterns
  localparam logic [31:0] SFN_INDEF_S    = 32'hffc00000;
  localparam logic [63:0] SFN_INDEF_D    = 64'h00fff80000000000;
  localparam logic [31:0] SFN_QUIET_S    = 32'h00400000;
  localparam logic [63:0] SFN_QUIET_D    = 64'h0008000000000000;
  localparam logic [31:0] SFN_INT_INDEF  = 32'h80000000;

  // Operation codes
  typedef enum logic [2:0] {
    SFN_OP_ADD    = 3'b000,
    SFN_OP_SUB    = 3'b001,
    SFN_OP_MUL    = 3'b010,
    SFN_OP_DIV    = 3'b011,
    SFN_OP_ADDSUB = 3'b100,
    SFN_OP_HADD   = 3'b101,
    SFN_OP_HSUB   = 3'b110
  } sfn_op_t;
endpackage

// File: rtl/sfn_nan_unit.sv
/*
  Exception detection and NaN-result selection for packed and scalar
  add, subtract, multiply, divide and horizontal add/subtract.
  Assumes the arithmetic datapath presents its raw per-lane result and
  its post-computation overflow/underflow/inexact per lane in the same
  cycle as the operands, with operand pairs already arranged per lane.
*/
`timescale 1ns/1ps

// Operation
// - six exception conditions, each flag and mask
// - invalid, zero-divide, denormal checked before compute
// - overflow, underflow, inexact checked after compute
// - masked condition gives defined result, no exception
// - mixed masked and unmasked: no masked results
// - unmasked exception writes no result
// - masked exception result plus status flag
// - NaN handling precedes non-invalid exceptions
// - single indefinite is ffc00000
// - double indefinite taken as printed
// - integer indefinite is 80000000
// - non-exceptional cases identical masked or unmasked
// - signaling NaN quieted, first NaN wins
// - two quiet NaNs return the first
// - quiet NaN with real returns quiet NaN
// - invalid arithmetic gives precision indefinite
// - up to four lanes checked separately
// - packed flags are OR of lanes
// - unmasked exception raised at once, vector 19
// - old flag never raises on unmask
module sfn_nan_unit
  import sfn_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // Register port
  input  wire logic [SFN_AW-1:0]  reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  // Operation request
  input  wire logic               op_valid,
  input  wire logic [2:0]         op_code,
  input  wire logic               op_double,
  input  wire logic               op_packed,
  input  wire logic [127:0]       opd_a,
  input  wire logic [127:0]       opd_b,
  // Arithmetic datapath results
  input  wire logic [127:0]       arith_result,
  input  wire logic [3:0]         arith_ovf,
  input  wire logic [3:0]         arith_unf,
  input  wire logic [3:0]         arith_inx,
  // Result and exception
  output logic                    res_valid,
  output logic                    res_write,
  output logic      [127:0]       res_data,
  output logic      [5:0]         res_detect,
  output logic                    exc_raise,
  output logic      [7:0]         simd_fp_exception_vector,
  // Conversion helper
  output logic      [31:0]        int_indefinite
);

  // Operand class: {nan, signaling, inf, zero, denormal, sign}
  function automatic logic [5:0] classify(input logic dbl, input logic [63:0] x);
    logic e1;
    logic e0;
    logic m0;
    logic mq;
    logic s;
    begin
      e1 = dbl ? (&x[62:52]) : (&x[30:23]);
      e0 = dbl ? ~(|x[62:52]) : ~(|x[30:23]);
      m0 = dbl ? ~(|x[51:0]) : ~(|x[22:0]);
      mq = dbl ? x[51] : x[22];
      s  = dbl ? x[63] : x[31];
      classify = {e1 & ~m0, e1 & ~m0 & ~mq, e1 & m0, e0 & m0, e0 & ~m0, s};
    end
  endfunction

  // One lane: returns {flags[5:0], nan_result, value[63:0]}
  function automatic logic [70:0] lane_eval(
    input logic       dbl,
    input logic [63:0] a,
    input logic [63:0] b,
    input logic [2:0] op,
    input logic       odd,
    input logic [2:0] trp
  );
    logic [5:0]  ca;
    logic [5:0]  cb;
    logic        sub;
    logic        addl;
    logic        anyn;
    logic        inv_ar;
    logic        dz;
    logic        den;
    logic [2:0]  tg;
    logic [63:0] v;
    logic [63:0] qb;
    begin
      ca   = classify(dbl, a);
      cb   = classify(dbl, b);
      sub  = (op == SFN_OP_SUB) || (op == SFN_OP_HSUB) || ((op == SFN_OP_ADDSUB) && !odd);
      addl = (op != SFN_OP_MUL) && (op != SFN_OP_DIV);
      anyn = ca[5] | cb[5];
      qb   = dbl ? SFN_QUIET_D : {32'h0, SFN_QUIET_S};
      // Invalid arithmetic on non-NaN operands
      inv_ar = !anyn && ((addl && ca[3] && cb[3] && (ca[0] ^ cb[0] ^ sub)) ||
               ((op == SFN_OP_MUL) && ((ca[3] && cb[2]) || (ca[2] && cb[3]))) ||
               ((op == SFN_OP_DIV) && ((ca[3] && cb[3]) || (ca[2] && cb[2]))));
      dz  = !anyn && (op == SFN_OP_DIV) && cb[2] && !ca[2] && !ca[3];
      den = !anyn && (ca[1] | cb[1]);
      // NaN or invalid lanes never reach the post-computation checks
      tg  = (anyn | inv_ar | dz) ? 3'b000 : trp;
      if (ca[5] && ca[4]) begin
        v = a | qb;
      end else if (ca[5]) begin
        v = a;
      end else if (cb[5] && cb[4]) begin
        v = b | qb;
      end else if (cb[5]) begin
        v = b;
      end else if (dbl) begin
        v = SFN_INDEF_D;
      end else begin
        v = {32'h0, SFN_INDEF_S};
      end
      // Quiet-only NaN cases raise nothing
      lane_eval = {tg, dz, den, (ca[4] | cb[4] | inv_ar), (anyn | inv_ar), v};
    end
  endfunction

  // Per-lane evaluation
  logic [70:0]  lane_out [SFN_LANES];
  logic [5:0]   cls_a    [SFN_LANES];
  logic [5:0]   cls_b    [SFN_LANES];
  logic [3:0]   lane_act;
  logic [127:0] lane_val;

  genvar gi;
  generate
    for (gi = 0; gi < SFN_LANES; gi++) begin : g_lane
      logic [63:0] la;
      logic [63:0] lb;
      logic [63:0] lr;
      // Lane slices by precision; double uses lanes 0 and 1 only
      always_comb begin
        if (op_double && (gi < 2)) begin
          la = opd_a[64*gi +: 64];
          lb = opd_b[64*gi +: 64];
          lr = arith_result[64*gi +: 64];
        end else begin
          la = {32'h0, opd_a[32*gi +: 32]};
          lb = {32'h0, opd_b[32*gi +: 32]};
          lr = {32'h0, arith_result[32*gi +: 32]};
        end
        lane_act[gi] = op_packed ? (!op_double || (gi < 2)) : (gi == 0);
        lane_out[gi] = lane_eval(op_double, la, lb, op_code, ((gi % 2) == 1),
                                 {arith_inx[gi], arith_unf[gi], arith_ovf[gi]});
        cls_a[gi]    = classify(op_double, la);
        cls_b[gi]    = classify(op_double, lb);
        // Masked result: NaN or indefinite wins over the raw result
        if (lane_out[gi][64]) begin
          lane_val[32*gi +: 32] = op_double ? lane_out[gi][31:0] : lane_out[gi][31:0];
        end else begin
          lane_val[32*gi +: 32] = lr[31:0];
        end
      end
    end
  endgenerate

  // Combine lanes, decide on the exception, assemble the result
  logic [5:0]   det_fault;
  logic [5:0]   det_trap;
  logic [5:0]   det;
  logic         raise;
  logic [127:0] masked_data;
  logic [5:0]   mask_q;
  logic [5:0]   flags_q;
  always_comb begin
    det_fault = 6'h00;
    det_trap  = 6'h00;
    for (int i = 0; i < SFN_LANES; i++) begin
      if (lane_act[i]) begin
        det_fault = det_fault | {3'b000, lane_out[i][67:65]};
        det_trap  = det_trap | {lane_out[i][70:68], 3'b000};
      end
    end
    // An unmasked fault stops the computation, so no trap is seen
    det   = (|(det_fault & ~mask_q)) ? det_fault : (det_fault | det_trap);
    raise = |(det & ~mask_q);
    masked_data = opd_a;
    if (op_double) begin
      for (int j = 0; j < 2; j++) begin
        if (lane_act[j]) begin
          masked_data[64*j +: 64] = lane_out[j][64] ? lane_out[j][63:0]
                                                    : arith_result[64*j +: 64];
        end
      end
    end else begin
      for (int j = 0; j < SFN_LANES; j++) begin
        if (lane_act[j]) begin
          masked_data[32*j +: 32] = lane_val[32*j +: 32];
        end
      end
    end
  end

  // Result stage
  logic         res_valid_q, res_valid_d;
  logic         res_write_q, res_write_d;
  logic         exc_q, exc_d;
  logic [127:0] res_data_q, res_data_d;
  logic [5:0]   det_q, det_d;
  logic [7:0]   vec_q, vec_d;
  always_comb begin
    res_valid_d = op_valid;
    res_write_d = op_valid && !raise;
    exc_d       = op_valid && raise;
    det_d       = op_valid ? det : 6'h00;
    vec_d       = (op_valid && raise) ? SFN_EXC_VECTOR : 8'h00;
    // Unmasked: destination keeps its original value
    res_data_d  = (op_valid && !raise) ? masked_data : opd_a;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      res_valid_q <= 1'b0;
      res_write_q <= 1'b0;
      exc_q       <= 1'b0;
      det_q       <= 6'h00;
      vec_q       <= 8'h00;
      res_data_q  <= 128'h0;
    end else begin
      res_valid_q <= res_valid_d;
      res_write_q <= res_write_d;
      exc_q       <= exc_d;
      det_q       <= det_d;
      vec_q       <= vec_d;
      res_data_q  <= res_data_d;
    end
  end

  // Control/status register: sticky flags, masks, read port
  logic [5:0]  mask_d;
  logic [5:0]  flags_d;
  logic [31:0] rdata_q, rdata_d;
  logic        csr_wr;
  always_comb begin
    csr_wr  = reg_wr && (reg_addr == SFN_ADDR_CSR);
    mask_d  = csr_wr ? reg_wdata[SFN_MASK_LSB +: SFN_NEXC] : mask_q;
    flags_d = csr_wr ? reg_wdata[SFN_FLAG_LSB +: SFN_NEXC] : flags_q;
    // A detection in the clearing cycle still sets the flag
    flags_d = flags_d | (op_valid ? det : 6'h00);
    rdata_d = 32'h0;
    if (reg_rd && (reg_addr == SFN_ADDR_CSR)) begin
      rdata_d[SFN_FLAG_LSB +: SFN_NEXC] = flags_q;
      rdata_d[SFN_MASK_LSB +: SFN_NEXC] = mask_q;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q  <= SFN_MASK_RST;
      flags_q <= SFN_FLAG_RST;
      rdata_q <= 32'h0;
    end else begin
      mask_q  <= mask_d;
      flags_q <= flags_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign reg_rdata                = rdata_q;
  assign res_valid                = res_valid_q;
  assign res_write                = res_write_q;
  assign res_data                 = res_data_q;
  assign res_detect               = det_q;
  assign exc_raise                = exc_q;
  assign simd_fp_exception_vector = vec_q;
  assign int_indefinite           = SFN_INT_INDEF;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_result_latency: assert property (op_valid |=> res_valid)
    else $error("result not one cycle after request");
  a_unmasked_nowrite: assert property (exc_raise |-> res_valid && !res_write)
    else $error("result written on unmasked exception");
  a_masked_write: assert property (res_valid && !exc_raise |-> res_write)
    else $error("masked result not written");
  a_raise_vector: assert property (exc_raise |-> simd_fp_exception_vector == 8'h13)
    else $error("wrong exception vector");
  a_flags_sticky: assert property (!csr_wr |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("status flag dropped without write");
  a_flags_or: assert property (res_valid |-> (flags_q & det_q) == det_q)
    else $error("detected condition not in flags");
  a_raise_cause: assert property (op_valid ##1 exc_raise |-> (det_q & ~$past(mask_q)) != 6'h00)
    else $error("exception without new unmasked condition");
  a_trap_gated: assert property (
      op_valid && (|(det_fault & ~mask_q)) |=> det_q[5:3] == 3'b000)
    else $error("trap flag beside unmasked fault");
  a_signaling_not_a_number_quiet: assert property (
      op_valid && !op_double && lane_act[0] && cls_a[0][4] && !raise
      |=> res_data[31:0] == ($past(opd_a[31:0]) | 32'h00400000))
    else $error("signaling NaN not quieted");
  a_quiet_not_a_number_first: assert property (
      op_valid && !op_double && !op_packed && cls_a[0][5] && !cls_a[0][4] && !cls_b[0][4]
      && !raise |=> res_data[31:0] == $past(opd_a[31:0]) && !res_detect[0])
    else $error("quiet NaN not passed through");
  a_indef_single: assert property (
      op_valid && !op_double && lane_act[0] && !cls_a[0][5] && !cls_b[0][5]
      && lane_out[0][65] && !raise |=> res_data[31:0] == 32'hffc00000)
    else $error("single indefinite wrong");

  c_masked_nan: cover property (op_valid && !raise && (det[0]));
  c_unmasked_fault: cover property (op_valid && raise && (|det_fault));
  c_packed_trap: cover property (op_valid && op_packed && (|det_trap));
endmodule

// File: tb/simd_fp_nan_exception_response_tb.sv
/*
  Self-checking bench for sfn_nan_unit with a lane model of NaN results and flags.
  Assumes one-cycle answers on both the register port and the operation port.
*/
`timescale 1ns/1ps
module simd_fp_nan_exception_response_tb
  import sfn_pkg::*;
;
  logic              clock, rst, reg_wr, reg_rd, op_valid, op_double, op_packed, d, p;
  logic [SFN_AW-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, int_indefinite;
  logic [2:0]        op_code;
  logic [127:0]      opd_a, opd_b, arith_result, res_data;
  logic [3:0]        arith_ovf, arith_unf, arith_inx;
  logic              res_valid, res_write, exc_raise;
  logic [5:0]        res_detect, mask_m, flag_m;
  logic [7:0]        simd_fp_exception_vector;
  integer            failures, checks_done, seed;

  sfn_nan_unit DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
    .op_code(op_code), .op_double(op_double), .op_packed(op_packed), .opd_a(opd_a),
    .opd_b(opd_b), .arith_result(arith_result), .arith_ovf(arith_ovf),
    .arith_unf(arith_unf), .arith_inx(arith_inx), .res_valid(res_valid),
    .res_write(res_write), .res_data(res_data), .res_detect(res_detect),
    .exc_raise(exc_raise), .simd_fp_exception_vector(simd_fp_exception_vector),
    .int_indefinite(int_indefinite));

  // Free-running core clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Compare and count
  task automatic chk(logic [127:0] got, logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Counts, verdict, end of run
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Register write, model follows the mapped address only
  task automatic wr(logic [3:0] ad, logic [31:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (ad == SFN_ADDR_CSR) begin
      flag_m = v[5:0];
      mask_m = v[13:8];
    end
  endtask

  // Register read, data looked at in the cycle after the strobe
  task automatic rd(logic [3:0] ad);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, ad == SFN_ADDR_CSR ? {18'h0, mask_m, 2'h0, flag_m} : 0);
  endtask

  // Sign, exponent all ones, exponent zero, significand zero
  function automatic logic [3:0] fld(logic [63:0] x, logic dbl);
    if (dbl) return {x[63], &x[62:52], ~|x[62:52], ~|x[51:0]};
    return {x[31], &x[30:23], ~|x[30:23], ~|x[22:0]};
  endfunction

  // Random normal operands, never NaN, zero or denormal
  function automatic logic [127:0] rnd(logic dbl);
    logic [127:0] v;
    for (int i = 0; i < 4; i++) begin
      v[32*i+:32] = $random(seed);
      if (!dbl) v[32*i+23+:8] = 8'(1 + {$random(seed)} % 254);
      else if (i % 2) v[32*i+20+:11] = 11'(1 + {$random(seed)} % 2046);
    end
    return v;
  endfunction

  // Model one operation, drive it, compare the answer a cycle later
  task automatic op(logic [2:0] c, logic dbl, logic pk, logic [127:0] a, logic [127:0] b,
                    logic [127:0] r, logic [3:0] ov, logic [3:0] un, logic [3:0] ix);
    logic [63:0]  x, y, z, q;
    logic [3:0]   fa, fb;
    logic [5:0]   det;
    logic [2:0]   tr;
    logic [127:0] ed;
    logic         sub, na, nb, ia, ib, za, zb, bad, rz, sk;
    int           n;
    n = pk ? (dbl ? 2 : 4) : 1;
    q = dbl ? SFN_QUIET_D : {32'h0, SFN_QUIET_S};
    ed = a;
    det = 0;
    tr = 0;
    for (int i = 0; i < n; i++) begin
      x = dbl ? a[64*i+:64] : {32'h0, a[32*i+:32]};
      y = dbl ? b[64*i+:64] : {32'h0, b[32*i+:32]};
      z = dbl ? r[64*i+:64] : {32'h0, r[32*i+:32]};
      fa = fld(x, dbl);
      fb = fld(y, dbl);
      na = fa[2] & !fa[0];
      nb = fb[2] & !fb[0];
      ia = fa[2] & fa[0];
      ib = fb[2] & fb[0];
      za = fa[1] & fa[0];
      zb = fb[1] & fb[0];
      sub = c == SFN_OP_SUB || c == SFN_OP_HSUB || (c == SFN_OP_ADDSUB && i % 2 == 0);
      bad = c == SFN_OP_MUL ? (ia & zb) | (za & ib) :
            c == SFN_OP_DIV ? (ia & ib) | (za & zb) : ia & ib & ((fa[3] ^ fb[3]) != sub);
      sk = 1'b1;
      if (na) begin
        det[0] = det[0] | ~|(x & q) | (nb & ~|(y & q));
        z = x | q;
      end else if (nb) begin
        det[0] = det[0] | ~|(y & q);
        z = y | q;
      end else if (bad) begin
        det[0] = 1'b1;
        z = dbl ? SFN_INDEF_D : {32'h0, SFN_INDEF_S};
      end else begin
        sk = c == SFN_OP_DIV && zb && !za && !ia;
        det[2] = det[2] | sk;
        det[1] = det[1] | (fa[1] & !fa[0]) | (fb[1] & !fb[0]);
      end
      if (dbl) ed[64*i+:64] = z;
      else ed[32*i+:32] = z[31:0];
      if (!sk) tr = tr | {ix[i], un[i], ov[i]};
    end
    if (!(|(det[2:0] & ~mask_m[2:0]))) det[5:3] = tr;
    rz = |(det & ~mask_m);
    flag_m = flag_m | det;
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= c;
    op_double <= dbl;
    op_packed <= pk;
    opd_a <= a;
    opd_b <= b;
    arith_result <= r;
    arith_ovf <= ov;
    arith_unf <= un;
    arith_inx <= ix;
    @(posedge clock);
    op_valid <= 1'b0;
    #1 chk(res_valid, 1'b1);
    chk(res_write, !rz);
    chk(res_data, rz ? a : ed);
    chk(res_detect, det);
    chk(exc_raise, rz);
    chk(simd_fp_exception_vector, rz ? SFN_EXC_VECTOR : 8'h0);
  endtask

  // Run length guard
  initial begin
    repeat (100000) @(posedge clock);
    failures++;
    test_done();
  end

  // Main sequence
  initial begin
    {seed, failures, checks_done} = {32'd8277, 64'd0};
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, op_valid, op_code} = {1'b1, 42'h0};
    {op_double, op_packed, opd_a, opd_b, arith_result} = 386'h0;
    {arith_ovf, arith_unf, arith_inx, d, p} = 14'h0;
    flag_m = SFN_FLAG_RST;
    mask_m = SFN_MASK_RST;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(4'h0);
    wr(4'h8, 32'hffff);
    rd(4'h4);
    rd(4'h0);
    chk(int_indefinite, 32'h80000000);
    $display("reset test done");
    op(SFN_OP_ADD, 0, 1, {32'h3f800000, 32'h7fc00001, 32'h7fc00002, 32'h7f800005},
       {32'h7fc00003, 32'hffc00007, 32'hff800003, 32'h7f800009}, rnd(0), 4'hf, 0, 0);
    op(SFN_OP_SUB, 0, 1, {32'h40400000, 32'hffc00010, 32'h3f800000, 32'hff800011},
       {32'h40000000, 32'h3f000000, 32'h7f800012, 32'h40000000}, rnd(0), 4'hc, 0, 0);
    op(SFN_OP_MUL, 1, 1, {64'h7ff0000000000009, 64'hfff8000000000002},
       {64'h7ff8000000000003, 64'h3ff0000000000000}, rnd(1), 4'h3, 0, 0);
    op(SFN_OP_ADDSUB, 0, 1, {4{32'h7f800000}},
       {32'h7f800000, 32'hff800000, 32'hff800000, 32'h7f800000}, rnd(0), 0, 0, 4'hf);
    op(SFN_OP_MUL, 1, 1, {64'h7ff0000000000000, 64'h0}, {64'h0, 64'h3ff0000000000000},
       rnd(1), 0, 4'h3, 0);
    op(SFN_OP_DIV, 1, 1, {64'h3ff0000000000000, 64'h0}, 0, rnd(1), 4'h3, 0, 0);
    op(SFN_OP_ADD, 0, 0, {{3{32'h7f800001}}, 32'h1}, 32'h3f800000, rnd(0), 4'hf, 0, 0);
    op(SFN_OP_MUL, 0, 0, 32'h7fc00005, 32'h7fc00009, rnd(0), 4'h1, 0, 0);
    rd(4'h0);
    $display("masked NaN test done");
    for (int k = 0; k < 28; k++) begin
      if (k % 7 == 0) wr(4'h0, {18'h0, 6'($random(seed)), 2'h0, 6'($random(seed))});
      d = $random(seed);
      p = $random(seed);
      op(3'(k % 7), d, p, rnd(d), rnd(d), {4{32'($random(seed))}},
         4'($random(seed)) & 4'($random(seed)), 4'($random(seed)) & 4'($random(seed)),
         4'($random(seed)));
    end
    rd(4'h0);
    $display("random test done");
    wr(4'h0, 32'h3e00);
    op(SFN_OP_ADD, 0, 0, 32'h7f800001, 32'h3f800000, rnd(0), 0, 0, 0);
    wr(4'h0, 32'h3700);
    op(SFN_OP_SUB, 0, 1, {32'h3f800000, 32'h7f800002}, 32'h3f800000, rnd(0), 4'h2, 0, 0);
    wr(4'h0, 32'h003f);
    op(SFN_OP_HADD, 0, 1, {4{32'h3f800000}}, {4{32'h40000000}}, rnd(0), 0, 0, 0);
    op(SFN_OP_DIV, 0, 1, {4{32'h3f800000}}, {{3{32'h40000000}}, 32'h0}, rnd(0), 4'hf, 0, 0);
    rd(4'h0);
    wr(4'h0, 32'h3f00);
    rd(4'h0);
    $display("unmasked test done");
    test_done();
  end
endmodule
